// [rtl/ccir_clock_ctrl.sv]
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Codes 29 give x30; 30 and 31 x31.
// R2: Software keeps multiplier output at most 100 MHz.
// R3: Doubling bit 17: 0 doubles, 1 not.
// R4: Source bit 16: 0 half RC, 1 crystal.
// R5: Bus2 divider bits 13:11 divide 1..16.
// R6: Bus1 divider bits 10:8 divide 1..16.
// R7: Fast bus divider bits 7:4 up to 256.
// R8: Status bits 3:2 show active system source.
// R9: Select bits 1:0 request source; 11 reserved.
// R10: Software polls status until switch completes.
// R11: Leaving low power forces RC selection.
// R12: Crystal failure while used forces RC selection.
// R13: Write one clears stuck flags 23:21.
// R14: Write one clears stable flags 20:16.
// R15: Bit 14 enables multiplier stuck interrupt.
// R16: Bit 13 enables slow crystal stuck interrupt.
// R17: Bit 12 enables multiplier stable interrupt.
// R18: Bit 11 enables fast crystal stable interrupt.
// R19: Software writes reserved bits with reset value.
// R20: Stable flags set only while enabled.
// R21: Crystal stuck sets flag; NMI enable clears.
// R22: Multiplier and slow crystal stuck set flags.
// R23: Clear bits read zero; flag writes ignored.
// R24: Interrupt while any enabled flag set.
module ccir_clock_ctrl
   import ccir_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [4:0] i_osc_stable,
   input wire logic [2:0] i_clk_stuck,
   input wire logic i_lowpower_exit,
   output logic [4:0] o_mult_factor,
   output logic o_mult_double,
   output logic o_mult_src_xtal,
   output logic [1:0] o_sysclk_active,
   output logic o_hsbus_tick,
   output logic o_pb1_tick,
   output logic o_pb2_tick,
   output logic o_irq,
   output logic o_nmi
);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave

   logic wait_q; // Waitrequest, low for exactly one cycle per access
   logic [31:0] rdata_q; // Read data, loaded as waitrequest falls
   logic [31:0] rmux; // Read data before the register
   logic wr_go; // Write takes effect at this edge
   logic [31:0] wmask; // Byte enables widened to bits
   logic wr_cfg; // Write to configuration register
   logic wr_evt; // Write to event register
   logic wr_aux; // Write to auxiliary register

   // Configuration fields
   logic [4:0] factor_q; // Multiplier factor code
   logic dbl_q; // Doubling bit, 0 selects doubled clock
   logic src_q; // Multiplier source bit
   logic [2:0] pb2_q; // Bus2 divider code
   logic [2:0] pb1_q; // Bus1 divider code
   logic [3:0] hs_q; // Fast bus divider code
   logic [1:0] sel_q; // Requested system source
   logic [1:0] status_q; // Active system source
   ccir_sw_t sw_q; // Switch sequencer state

   // Event fields
   logic [6:0] en_q; // Interrupt enables for flags 6..0
   logic nmi_en_q; // Crystal stuck NMI enable
   logic [7:0] flag; // Sticky flags
   logic [7:0] flag_set; // Hardware set events
   logic [7:0] flag_clr; // Software clear strobes
   logic [4:0] stb_prev_q; // Previous oscillator stable levels
   logic irq_q; // Registered interrupt request
   logic nmi_q; // Registered NMI request

   // Fallback
   logic fast_fail; // Crystal failed while it is requested or feeds the system clock
   logic force_rc; // Any forced return to the RC oscillator

   assign wr_go = i_avs_write & ~wait_q;
   assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign wr_cfg = wr_go & (i_avs_address == CCIR_OFS_CFG);
   assign wr_evt = wr_go & (i_avs_address == CCIR_OFS_EVT);
   assign wr_aux = wr_go & (i_avs_address == CCIR_OFS_AUX);

   // One wait cycle, then a single accepting cycle; keeps read data registered
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wait_q <= 1'b1;
      end else if ((i_avs_read | i_avs_write) & wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      rmux = 32'h0000_0000;
      case (i_avs_address)
         CCIR_OFS_CFG: begin
            rmux[CCIR_CFG_FACTOR_HI] = factor_q[4];
            rmux[CCIR_CFG_FACTOR_LO +: 4] = factor_q[3:0];
            rmux[CCIR_CFG_DBL] = dbl_q;
            rmux[CCIR_CFG_SRC] = src_q;
            rmux[CCIR_CFG_PB2 +: 3] = pb2_q;
            rmux[CCIR_CFG_PB1 +: 3] = pb1_q;
            rmux[CCIR_CFG_HS +: 4] = hs_q;
            rmux[CCIR_CFG_STAT +: 2] = status_q; // [R8]
            rmux[CCIR_CFG_SEL +: 2] = sel_q;
         end
         CCIR_OFS_EVT: begin
            // Clear bits are write-only and read as zero [R23]
            rmux[CCIR_EVT_EN +: 7] = en_q;
            rmux[CCIR_EVT_FLAG +: 8] = flag;
         end
         CCIR_OFS_AUX: begin
            rmux[CCIR_AUX_NMI_EN] = nmi_en_q;
         end
         default: begin
            rmux = 32'h0000_0000;
         end
      endcase
   end

   // Capture read data as waitrequest drops
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_q <= 32'h0000_0000;
      end else if (i_avs_read & wait_q) begin
         rdata_q <= rmux;
      end
   end

   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration register

   // Multiplier and divider fields, byte-lane masked
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         factor_q <= 5'h00;
         dbl_q <= CCIR_DBL_RESET;
         src_q <= 1'b0;
         pb2_q <= 3'h0;
         pb1_q <= 3'h0;
         hs_q <= 4'h0;
      end else if (wr_cfg) begin
         if (wmask[CCIR_CFG_FACTOR_HI]) begin
            factor_q[4] <= i_avs_writedata[CCIR_CFG_FACTOR_HI];
         end
         if (wmask[CCIR_CFG_FACTOR_LO]) begin
            factor_q[3:0] <= i_avs_writedata[CCIR_CFG_FACTOR_LO +: 4];
            dbl_q <= i_avs_writedata[CCIR_CFG_DBL];
            src_q <= i_avs_writedata[CCIR_CFG_SRC];
         end
         if (wmask[CCIR_CFG_PB1]) begin
            pb2_q <= i_avs_writedata[CCIR_CFG_PB2 +: 3];
            pb1_q <= i_avs_writedata[CCIR_CFG_PB1 +: 3];
         end
         if (wmask[CCIR_CFG_HS]) begin
            hs_q <= i_avs_writedata[CCIR_CFG_HS +: 4];
         end
      end
   end

   // Crystal failure counts only while the crystal is requested or feeds the system clock
   assign fast_fail = i_clk_stuck[2] &
      ((sel_q == CCIR_SRC_XTAL) | (status_q == CCIR_SRC_XTAL) |
       (((sel_q == CCIR_SRC_MULT) | (status_q == CCIR_SRC_MULT)) & src_q));
   assign force_rc = i_lowpower_exit | fast_fail;

   // Source request; forcing beats a software write, reserved code is dropped
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sel_q <= CCIR_SRC_RC;
      end else if (force_rc) begin
         sel_q <= CCIR_SRC_RC; // [R11] [R12]
      end else if (wr_cfg & wmask[CCIR_CFG_SEL] &
                   (i_avs_writedata[CCIR_CFG_SEL +: 2] != CCIR_SRC_RSVD)) begin
         sel_q <= i_avs_writedata[CCIR_CFG_SEL +: 2]; // [R9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // System clock switch

   // Status follows the request once the target source reports stable;
   // an unstable target leaves the old source running until it is
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sw_q <= CCIR_SW_IDLE;
         status_q <= CCIR_SRC_RC;
      end else begin
         case (sw_q)
            CCIR_SW_IDLE: begin
               if (sel_q != status_q) begin
                  sw_q <= CCIR_SW_WAIT;
               end
            end
            CCIR_SW_WAIT: begin
               if (sel_q == status_q) begin
                  sw_q <= CCIR_SW_IDLE;
               end else if ((sel_q == CCIR_SRC_RC && i_osc_stable[CCIR_FLG_RCF_STB]) ||
                            (sel_q == CCIR_SRC_XTAL && i_osc_stable[CCIR_FLG_FAST_STB]) ||
                            (sel_q == CCIR_SRC_MULT && i_osc_stable[CCIR_FLG_MULT_STB])) begin
                  status_q <= sel_q; // [R8]
                  sw_q <= CCIR_SW_IDLE;
               end
            end
            default: begin
               sw_q <= CCIR_SW_IDLE;
            end
         endcase
      end
   end

   // Registered controls towards the multiplier and clock mux
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_mult_factor <= 5'h02;
         o_mult_double <= ~CCIR_DBL_RESET;
         o_mult_src_xtal <= 1'b0;
         o_sysclk_active <= CCIR_SRC_RC;
      end else begin
         o_mult_factor <= ccir_factor_value(factor_q); // [R1]
         o_mult_double <= ~dbl_q; // [R3]
         o_mult_src_xtal <= src_q; // [R4]
         o_sysclk_active <= status_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus clock dividers

   ccir_div_if hs_if();
   ccir_div_if p1_if();
   ccir_div_if p2_if();

   // Fast bus ticks from every system clock; peripheral buses from fast bus ticks
   assign hs_if.in_tick = 1'b1;
   assign hs_if.shift = ccir_hs_shift(hs_q); // [R7]
   assign p1_if.in_tick = hs_if.out_tick;
   assign p1_if.shift = ccir_pb_shift(pb1_q); // [R6]
   assign p2_if.in_tick = hs_if.out_tick;
   assign p2_if.shift = ccir_pb_shift(pb2_q); // [R5]

   ccir_tick_div u_hs_div (.i_clk(i_clk), .i_rstn(i_rstn), .bus(hs_if.div));
   ccir_tick_div u_p1_div (.i_clk(i_clk), .i_rstn(i_rstn), .bus(p1_if.div));
   ccir_tick_div u_p2_div (.i_clk(i_clk), .i_rstn(i_rstn), .bus(p2_if.div));

   assign o_hsbus_tick = hs_if.out_tick;
   assign o_pb1_tick = p1_if.out_tick;
   assign o_pb2_tick = p2_if.out_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Event register

   // Enables are plain read-write; flag bits 7:0 ignore writes [R23]
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         en_q <= CCIR_EVT_RESET[CCIR_EVT_EN +: 7];
      end else if (wr_evt & wmask[CCIR_EVT_EN]) begin
         en_q <= i_avs_writedata[CCIR_EVT_EN +: 7]; // [R15] [R16] [R17] [R18]
      end
   end

   // NMI enable lives in its own register
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         nmi_en_q <= 1'b0;
      end else if (wr_aux & wmask[CCIR_AUX_NMI_EN]) begin
         nmi_en_q <= i_avs_writedata[CCIR_AUX_NMI_EN];
      end
   end

   // Edge detect on stable levels so a held level sets a flag once
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         stb_prev_q <= 5'h00;
      end else begin
         stb_prev_q <= i_osc_stable;
      end
   end

   // Stable flags only with their enable; stuck flags always
   assign flag_set[4:0] = i_osc_stable & ~stb_prev_q & en_q[4:0]; // [R20]
   assign flag_set[7:5] = i_clk_stuck; // [R21] [R22]

   // Write-one clears; a written NMI enable of one also clears the crystal flag
   assign flag_clr[6:0] = {7{wr_evt & wmask[CCIR_EVT_CLR]}} &
                          i_avs_writedata[CCIR_EVT_CLR +: 7]; // [R13] [R14]
   assign flag_clr[7] = (wr_evt & wmask[CCIR_EVT_CLR + 7] &
                         i_avs_writedata[CCIR_EVT_CLR + 7]) |
                        (wr_aux & wmask[CCIR_AUX_NMI_EN] &
                         i_avs_writedata[CCIR_AUX_NMI_EN]); // [R13] [R21]

   for (genvar g = 0; g < 8; g++) begin : g_flag
      ccir_flag_cell u_flag (
         .i_clk(i_clk),
         .i_rstn(i_rstn),
         .i_set(flag_set[g]),
         .i_clr(flag_clr[g]),
         .o_flag(flag[g])
      );
   end

   // Interrupt and NMI requests follow the enabled flags
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_q <= 1'b0;
         nmi_q <= 1'b0;
      end else begin
         irq_q <= |(flag[6:0] & en_q); // [R24]
         nmi_q <= flag[CCIR_FLG_FAST_STUCK] & nmi_en_q;
      end
   end

   assign o_irq = irq_q;
   assign o_nmi = nmi_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   property p_factor_top;
      (factor_q inside {5'h1E, 5'h1F}) |=> (o_mult_factor == 5'h1F);
   endproperty
   a_factor_top: assert property (p_factor_top) else $error("factor top code wrong"); // [R1]

   property p_double;
      ##1 (o_mult_double != $past(dbl_q)) && (o_mult_src_xtal == $past(src_q));
   endproperty
   a_double: assert property (p_double) else $error("multiplier control wrong"); // [R3]

   property p_status_switch;
      (sw_q == CCIR_SW_WAIT && sel_q == CCIR_SRC_MULT && i_osc_stable[4] && status_q != sel_q)
         |=> (status_q == CCIR_SRC_MULT) ##1 (o_sysclk_active == CCIR_SRC_MULT);
   endproperty
   a_status_switch: assert property (p_status_switch) else $error("status not updated"); // [R8]

   property p_sel_rsvd;
      (sel_q != CCIR_SRC_RSVD) && (status_q != CCIR_SRC_RSVD);
   endproperty
   a_sel_rsvd: assert property (p_sel_rsvd) else $error("reserved source held"); // [R9]

   property p_lowpower;
      i_lowpower_exit |=> (sel_q == CCIR_SRC_RC);
   endproperty
   a_lowpower: assert property (p_lowpower) else $error("no fallback on wake"); // [R11]

   property p_fail;
      (i_clk_stuck[2] && sel_q == CCIR_SRC_XTAL) |=> (sel_q == CCIR_SRC_RC) && flag[7];
   endproperty
   a_fail: assert property (p_fail) else $error("no fallback on failure"); // [R12]

   property p_clear;
      (wr_evt && wmask[22] && i_avs_writedata[22] && !i_clk_stuck[1]) |=> !flag[6];
   endproperty
   a_clear: assert property (p_clear) else $error("stuck flag not cleared"); // [R13]

   property p_stable_gate;
      $rose(flag[CCIR_FLG_MULT_STB]) |-> $past(en_q[4]);
   endproperty
   a_stable_gate: assert property (p_stable_gate) else $error("flag set while disabled"); // [R20]

   property p_irq;
      (|(flag[6:0] & en_q)) |=> o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing"); // [R24]

   property p_rd_clear_zero;
      (i_avs_read && !wait_q && i_avs_address == CCIR_OFS_EVT) |-> (o_avs_readdata[31:15] == 17'h0);
   endproperty
   a_rd_clear_zero: assert property (p_rd_clear_zero) else $error("clear bits read nonzero"); // [R23]

   c_switch_mult: cover property (sw_q == CCIR_SW_WAIT ##1 status_q == CCIR_SRC_MULT);
   c_irq: cover property ($rose(o_irq));
   c_fallback: cover property (fast_fail ##1 sel_q == CCIR_SRC_RC);

endmodule : ccir_clock_ctrl
`default_nettype wire

// [rtl/ccir_pkg.sv]
package ccir_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [7:0] CCIR_OFS_CFG = 8'h04;
   localparam logic [7:0] CCIR_OFS_EVT = 8'h08;
   localparam logic [7:0] CCIR_OFS_AUX = 8'h10;

   // Configuration register field positions
   localparam int CCIR_CFG_FACTOR_HI = 27;
   localparam int CCIR_CFG_FACTOR_LO = 18;
   localparam int CCIR_CFG_DBL = 17;
   localparam int CCIR_CFG_SRC = 16;
   localparam int CCIR_CFG_PB2 = 11;
   localparam int CCIR_CFG_PB1 = 8;
   localparam int CCIR_CFG_HS = 4;
   localparam int CCIR_CFG_STAT = 2;
   localparam int CCIR_CFG_SEL = 0;

   // Event register field positions
   localparam int CCIR_EVT_CLR = 16;
   localparam int CCIR_EVT_EN = 8;
   localparam int CCIR_EVT_FLAG = 0;
   localparam int CCIR_AUX_NMI_EN = 0;

   // Flag indices inside the event register
   localparam int CCIR_FLG_FAST_STUCK = 7;
   localparam int CCIR_FLG_MULT_STUCK = 6;
   localparam int CCIR_FLG_SLOW_STUCK = 5;
   localparam int CCIR_FLG_MULT_STB = 4;
   localparam int CCIR_FLG_FAST_STB = 3;
   localparam int CCIR_FLG_RCF_STB = 2;

   // Reset values
   localparam logic [31:0] CCIR_CFG_RESET = 32'h0002_0000;
   localparam logic [31:0] CCIR_EVT_RESET = 32'h0000_0000;
   localparam logic CCIR_DBL_RESET = 1'h1;

   // System clock source codes, shared by select and status
   localparam logic [1:0] CCIR_SRC_RC = 2'h0;
   localparam logic [1:0] CCIR_SRC_XTAL = 2'h1;
   localparam logic [1:0] CCIR_SRC_MULT = 2'h2;
   localparam logic [1:0] CCIR_SRC_RSVD = 2'h3;

   // Clock switch sequencer
   typedef enum logic [0:0] {CCIR_SW_IDLE, CCIR_SW_WAIT} ccir_sw_t;

   // Multiplier factor code to multiply value
   function automatic logic [4:0] ccir_factor_value(input logic [4:0] code);
      if (code < 5'hE) begin
         return 5'(code + 5'h2);
      end else if (code < 5'h10) begin
         return 5'h10;
      end else if (code == 5'h1F) begin
         return 5'h1F;
      end
      return 5'(code + 5'h1);
   endfunction : ccir_factor_value

   // High-speed bus divider code to log2 of the ratio
   function automatic logic [3:0] ccir_hs_shift(input logic [3:0] code);
      case (code)
         4'h8: return 4'h1;
         4'h9: return 4'h2;
         4'hA: return 4'h3;
         4'hB: return 4'h4;
         4'hC: return 4'h6;
         4'hD: return 4'h7;
         4'hE: return 4'h8;
         4'hF: return 4'h8;
         default: return 4'h0;
      endcase
   endfunction : ccir_hs_shift

   // Peripheral bus divider code to log2 of the ratio
   function automatic logic [3:0] ccir_pb_shift(input logic [2:0] code);
      return code[2] ? 4'({2'h0, code[1:0]} + 4'h1) : 4'h0;
   endfunction : ccir_pb_shift

endpackage : ccir_pkg

// [rtl/ccir_div_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Carries one divider stage: input ticks and ratio in, divided ticks out
interface ccir_div_if;
   logic in_tick; // One tick per source period
   logic [3:0] shift; // log2 of the division ratio
   logic out_tick; // One tick per divided period
   modport src (output in_tick, output shift, input out_tick);
   modport div (input in_tick, input shift, output out_tick);
endinterface : ccir_div_if
`default_nettype wire

// [rtl/ccir_flag_cell.sv]
`timescale 1ns/1ps
`default_nettype none
module ccir_flag_cell (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_set,
   input wire logic i_clr,
   output logic o_flag
);
   // Sticky flag; an event in the clearing cycle is kept, so set wins
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clr) begin
         o_flag <= 1'b0;
      end
   end
endmodule : ccir_flag_cell
`default_nettype wire

// [rtl/ccir_tick_div.sv]
`timescale 1ns/1ps
`default_nettype none
module ccir_tick_div (
   input wire logic i_clk,
   input wire logic i_rstn,
   ccir_div_if.div bus
);
   logic [7:0] cnt_q; // Source ticks seen in this divided period
   logic [7:0] limit; // Last count of a period
   logic tick_q; // Registered divided tick

   // Ratio up to 256, so the limit always fits eight bits
   assign limit = 8'((9'h1 << bus.shift) - 9'h1);

   // Count source ticks; a ratio change takes effect at once, a count already past the new limit wrapping at the next source tick
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= 8'h00;
      end else if (bus.in_tick) begin
         cnt_q <= (cnt_q >= limit) ? 8'h00 : 8'(cnt_q + 8'h01);
      end
   end

   // One divided tick on the last source tick of each period
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= bus.in_tick & (cnt_q >= limit);
      end
   end

   assign bus.out_tick = tick_q;
endmodule : ccir_tick_div
`default_nettype wire

// [dv/ccir_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
   import ccir_pkg::*;
;
   logic i_clk, i_rstn, i_avs_read, i_avs_write, i_lowpower_exit;
   logic [7:0] i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, q, v;
   logic [3:0] i_avs_byteenable;
   logic [4:0] i_osc_stable, o_mult_factor;
   logic [2:0] i_clk_stuck;
   logic [1:0] o_sysclk_active;
   logic o_avs_waitrequest, o_mult_double, o_mult_src_xtal, o_hsbus_tick;
   logic o_pb1_tick, o_pb2_tick, o_irq, o_nmi;
   int num_errors = 0, total_checks = 0, cycles = 0;
   // Factor codes and multiply values, divider codes and ticks per 256 cycles
   logic [4:0] fc[8] = '{5'h00, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h1D, 5'h1E, 5'h1F};
   logic [4:0] fv[8] = '{5'h02, 5'h0F, 5'h10, 5'h10, 5'h11, 5'h1E, 5'h1F, 5'h1F};
   logic [3:0] hc[9] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
   int hn[9] = '{256, 256, 128, 64, 32, 16, 4, 2, 1};
   int pn[6] = '{256, 256, 128, 64, 32, 16};
   logic [2:0] pc[6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   ccir_clock_ctrl DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_osc_stable(i_osc_stable),
      .i_clk_stuck(i_clk_stuck), .i_lowpower_exit(i_lowpower_exit),
      .o_mult_factor(o_mult_factor), .o_mult_double(o_mult_double),
      .o_mult_src_xtal(o_mult_src_xtal), .o_sysclk_active(o_sysclk_active),
      .o_hsbus_tick(o_hsbus_tick), .o_pb1_tick(o_pb1_tick), .o_pb2_tick(o_pb2_tick),
      .o_irq(o_irq), .o_nmi(o_nmi));
   ////////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   // Hang guard, over twice the nearly 9000 cycles the run needs
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask : tick
   // One Avalon access; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      i_avs_read <= ~wr;
      i_avs_write <= wr;
      i_avs_address <= a;
      i_avs_writedata <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 50);
      check(n < 50, 32'h1);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : bus
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask : rdchk
   // Reserved fields always written as zero
   function automatic logic [31:0] cfgv(input logic [4:0] f, input logic d, input logic s,
         input logic [2:0] p2, input logic [2:0] p1, input logic [3:0] h, input logic [1:0] sel);
      return {4'h0, f[4], 5'h00, f[3:0], d, s, 2'h0, p2, p1, h, 2'h0, sel};
   endfunction : cfgv
   // Count pulses over 256 cycles after the new ratio has settled
   task automatic divchk(input logic [3:0] h, input logic [2:0] p, input int eh, input int ep);
      int nh, n1, n2;
      nh = 0;
      n1 = 0;
      n2 = 0;
      bus(1'b1, CCIR_OFS_CFG, cfgv(5'h00, 1'b1, 1'b0, p, p, h, CCIR_SRC_RC));
      tick(300);
      repeat (256) begin
         @(posedge i_clk);
         nh += o_hsbus_tick;
         n1 += o_pb1_tick;
         n2 += o_pb2_tick;
      end
      check(32'(nh), 32'(eh));
      check(32'(n1), 32'(ep));
      check(32'(n2), 32'(ep));
   endtask : divchk
   // Software polls status until it shows the wanted source
   task automatic poll(input logic [1:0] s);
      int n;
      n = 0;
      do begin
         bus(1'b0, CCIR_OFS_CFG, 32'h0);
         n++;
      end while (q[3:2] !== s && n < 40);
      check({28'h0, q[3:0]}, {28'h0, s, s});
   endtask : poll
   // Stable event is a rising level, stuck event a one-cycle pulse
   task automatic trig(input int k);
      if (k < 5) begin
         i_osc_stable[k] <= 1'b0;
         tick(2);
         i_osc_stable[k] <= 1'b1;
      end else begin
         i_clk_stuck[k-5] <= 1'b1;
         tick(1);
         i_clk_stuck[k-5] <= 1'b0;
      end
      tick(3);
   endtask : trig
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_rstn = 1'b0;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_address = 8'h00;
      i_avs_writedata = 32'h0;
      i_avs_byteenable = 4'hF;
      i_osc_stable = 5'h04;
      i_clk_stuck = 3'h0;
      i_lowpower_exit = 1'b0;
      tick(10);
      i_rstn <= 1'b1;
      tick(1);
      rdchk(CCIR_OFS_CFG, CCIR_CFG_RESET);
      rdchk(CCIR_OFS_EVT, CCIR_EVT_RESET);
      bus(1'b1, 8'h0C, 32'hFFFFFFFF);
      rdchk(8'h0C, 32'h0);
      // Only lane 1 enabled: peripheral bus dividers change, other lanes (fast bus divider included) keep reset values
      i_avs_byteenable <= 4'h2;
      bus(1'b1, CCIR_OFS_CFG, 32'h0FFF_3FF1);
      i_avs_byteenable <= 4'hF;
      rdchk(CCIR_OFS_CFG, 32'h0002_3F00);
      $display("test reset_map done");
      for (int i = 0; i < 8; i++) begin
         v = cfgv(fc[i], i[0], ~i[0], 3'h0, 3'h0, 4'h0, CCIR_SRC_RC);
         bus(1'b1, CCIR_OFS_CFG, v);
         rdchk(CCIR_OFS_CFG, v);
         check({27'h0, o_mult_factor}, {27'h0, fv[i]});
         check({30'h0, o_mult_double, o_mult_src_xtal}, {30'h0, ~i[0], ~i[0]});
      end
      $display("test multiplier done");
      for (int i = 0; i < 9; i++) divchk(hc[i], 3'h0, hn[i], hn[i]);
      for (int i = 0; i < 6; i++) divchk(4'h0, pc[i], 256, pn[i]);
      $display("test dividers done");
      i_osc_stable[3] <= 1'b1;
      bus(1'b1, CCIR_OFS_CFG, cfgv(5'h00, 1'b1, 1'b0, 3'h0, 3'h0, 4'h0, CCIR_SRC_XTAL));
      poll(CCIR_SRC_XTAL);
      check({30'h0, o_sysclk_active}, {30'h0, CCIR_SRC_XTAL});
      // Reserved select code leaves the old source in place
      bus(1'b1, CCIR_OFS_CFG, cfgv(5'h00, 1'b1, 1'b0, 3'h0, 3'h0, 4'h0, CCIR_SRC_RSVD));
      tick(4);
      poll(CCIR_SRC_XTAL);
      trig(7);
      poll(CCIR_SRC_RC);
      i_osc_stable[4] <= 1'b1;
      bus(1'b1, CCIR_OFS_CFG, cfgv(5'h00, 1'b1, 1'b0, 3'h0, 3'h0, 4'h0, CCIR_SRC_MULT));
      poll(CCIR_SRC_MULT);
      i_lowpower_exit <= 1'b1;
      tick(1);
      i_lowpower_exit <= 1'b0;
      poll(CCIR_SRC_RC);
      // Multiplier fed by the crystal: a crystal failure must still fall back
      bus(1'b1, CCIR_OFS_CFG, cfgv(5'h00, 1'b1, 1'b1, 3'h0, 3'h0, 4'h0, CCIR_SRC_MULT));
      poll(CCIR_SRC_MULT);
      trig(7);
      poll(CCIR_SRC_RC);
      $display("test switch done");
      rdchk(CCIR_OFS_EVT, 32'h80);
      bus(1'b1, CCIR_OFS_AUX, 32'h1);
      rdchk(CCIR_OFS_EVT, 32'h0);
      trig(7);
      check({31'h0, o_nmi}, 32'h1);
      bus(1'b1, CCIR_OFS_EVT, 32'h00800000);
      rdchk(CCIR_OFS_EVT, 32'h0);
      check({31'h0, o_nmi}, 32'h0);
      // Flags 0 to 6: masked event, enable (stable flags see a new event), then clear with flag bits poked
      for (int k = 0; k < 7; k++) begin
         bus(1'b1, CCIR_OFS_EVT, 32'h0);
         trig(k);
         rdchk(CCIR_OFS_EVT, (k > 4) ? (32'h1 << k) : 32'h0);
         check({31'h0, o_irq}, 32'h0);
         bus(1'b1, CCIR_OFS_EVT, 32'h1 << (8 + k));
         if (k < 5) trig(k);
         rdchk(CCIR_OFS_EVT, (32'h1 << k) | (32'h1 << (8 + k)));
         check({31'h0, o_irq}, 32'h1);
         bus(1'b1, CCIR_OFS_EVT, (32'h1 << (16 + k)) | (32'h1 << (8 + k)) | 32'hFF);
         rdchk(CCIR_OFS_EVT, 32'h1 << (8 + k));
         tick(1);
         check({31'h0, o_irq}, 32'h0);
      end
      $display("test events done");
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
